// [logic/charge_timer_thermistor_control.v]
// safety timer and thermistor control register with charge limits
//
// Notes on behaviour
// R1: slow timer by half in regulation modes
// R2: timer limit field selects 27m/6h/9h/off
// R3: thermistor enable bit, resets to one
// R4: fault 00 normal, 01 suspends charging
// R5: cool band: code 10, half current
// R6: warm band: code 11, voltage minus 140mV
// R7: half current select bit halves current
// R8: programmed current is 550mA plus weighted steps
`include "charge_timer_defines.vh"

// control register layout at its single offset:
//   bit 7     timer half rate enable
//   bits 6:5  fast-charge time limit, 11 switches the timer off
//   bit 4     spare, stored and read back with no function
//   bit 3     thermistor monitor enable
//   bits 2:1  thermistor fault code, read only
//   bit 0     half charge current select
// every other offset reads as zero and ignores writes.
// a write and a read in the same cycle return the old value.
//
// the temperature flags reach the charger controls three clocks after they
// move: two synchroniser stages and the output flop. the fault bits in
// the register follow the same path, so a read agrees with what the
// charger is being told.
//
// limitation: the timer restarts whenever fast charge drops, so a short
// dropout grants a fresh full limit; this keeps the timer simple at the
// cost of some margin.

module charge_timer_thermistor_control #(
    parameter TICKS_PER_SEC = `TICKS_PER_SEC, // shorten in simulation
    parameter WARM_COOL_BANDS = 1             // variant with extra bands
) (
    input wire clk,
    input wire rst_n,
    // register access from the serial interface engine
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // analog status, asynchronous to clk
    input wire thermal_reg_active,
    input wire input_current_limit_active,
    input wire input_voltage_regulation,
    input wire dynamic_path_power_mgmt,
    input wire fast_charge_active,
    input wire temp_below_cold,
    input wire temp_below_cool,
    input wire temp_above_warm,
    input wire temp_above_hot,
    // charge current code from the current register
    input wire [3:0] charge_current_code,
    // controls to the charger
    output reg charge_suspend,
    output reg charge_current_halved,
    output reg [10:0] charge_current_ma,
    output reg vreg_reduce,
    output reg [7:0] vreg_drop_mv,
    output reg safety_timer_expired
);
    // writable register fields
    reg timer_halfspeed_enable;
    reg timer_limit_hi;
    reg timer_limit_lo;
    reg spare_bit;                 // stored, no function
    reg thermistor_monitor_enable;
    reg half_current_select;

    // two-flop synchronisers for the analog flags
    reg [8:0] sync_a;
    reg [8:0] sync_b;
    wire [8:0] async_in;

    // fault decode and timer plumbing
    reg [1:0] next_fault;          // combinational fault code
    reg [1:0] fault_code;          // registered fault code
    // timer control
    wire slow_down;
    wire timer_expired;
    wire reg_hit;
    wire half_now;
    // charge current arithmetic, eleven bits of milliamps
    reg [10:0] full_ma;            // base plus steps
    reg [10:0] next_ma;            // after optional halving

    assign async_in = {thermal_reg_active, input_current_limit_active,
                       input_voltage_regulation, dynamic_path_power_mgmt,
                       fast_charge_active, temp_below_cold,
                       temp_below_cool, temp_above_warm, temp_above_hot};

    // a comparator can change anywhere in the cycle, so each flag passes
    // two flops; only the second stage feeds any logic
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 9'h000;
            sync_b <= 9'h000;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
        end
    end

    assign reg_hit = (reg_addr == `CTRL_REG_OFFSET);

    // register writes; fault bits are read only and ignore writes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // register defaults
            timer_halfspeed_enable <= `RST_TIMER_HALFSPEED; // see R1
            timer_limit_hi <= `RST_TIMER_LIMIT_HI;           // see R2
            timer_limit_lo <= `RST_TIMER_LIMIT_LO;           // see R2
            spare_bit <= `RST_SPARE;
            thermistor_monitor_enable <= `RST_THERM_ENABLE;  // see R3
            half_current_select <= `RST_HALF_CURRENT;        // see R7
        end else if (reg_wr && reg_hit) begin
            // a whole byte lands at once; the spare bit is kept so the
            // host reads back what it wrote
            timer_halfspeed_enable <= reg_wdata[`BIT_TIMER_HALFSPEED];
            timer_limit_hi <= reg_wdata[`BIT_TIMER_LIMIT_HI];
            timer_limit_lo <= reg_wdata[`BIT_TIMER_LIMIT_LO];
            spare_bit <= reg_wdata[`BIT_SPARE];
            thermistor_monitor_enable <= reg_wdata[`BIT_THERM_ENABLE];
            half_current_select <= reg_wdata[`BIT_HALF_CURRENT]; // see R7
        end
    end

    // read data registered one cycle after the strobe
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_hit) begin
                // the fault code is live status, not a stored field
                reg_rdata <= {timer_halfspeed_enable, timer_limit_hi,
                              timer_limit_lo, spare_bit,
                              thermistor_monitor_enable,
                              fault_code, half_current_select}; // see R4
            end else begin
                // unmapped addresses read as zero
                reg_rdata <= 8'h00;
            end
        end
    end

    // any regulation loop active slows the timer if enabled; with the
    // host flag clear the timer always runs at full rate
    assign slow_down = timer_halfspeed_enable &&
                       (sync_b[8] | sync_b[7] | sync_b[6] | sync_b[5]); // see R1

    // the timer sees the synchronised fast-charge level, so it starts two
    // clocks after the charger reports fast charge
    safety_timer #(
        .TICKS_PER_SEC(TICKS_PER_SEC)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .charge_active(sync_b[4]),
        .slow_down(slow_down),
        .limit_sel({timer_limit_hi, timer_limit_lo}),
        .expired(timer_expired)
    );

    // fault band decode; hot or cold dominates the softer bands
    // a disabled monitor reports no fault whatever the comparators say,
    // and the softer bands exist only on the variant that has them
    always @* begin
        next_fault = `FAULT_NONE;
        if (!thermistor_monitor_enable) begin
            next_fault = `FAULT_NONE;                          // see R3
        end else if (sync_b[3] || sync_b[0]) begin
            next_fault = `FAULT_SUSPEND;                       // see R4
        end else if (WARM_COOL_BANDS != 0 && sync_b[2]) begin
            next_fault = `FAULT_COOL;                          // see R5
        end else if (WARM_COOL_BANDS != 0 && sync_b[1]) begin
            next_fault = `FAULT_WARM;                          // see R6
        end
    end

    // halving comes from the host bit or the cool band
    assign half_now = half_current_select ||
                      (next_fault == `FAULT_COOL); // see R5 see R7

    // programmed current from base and steps, halved when asked;
    // the largest code stays well inside eleven bits, and halving
    // drops the odd milliamp, rounding down
    always @* begin
        full_ma = `ICHG_BASE_MA +
                  (`ICHG_STEP_MA * {7'h00, charge_current_code}); // see R8
        next_ma = half_now ? {1'b0, full_ma[10:1]} : full_ma;     // see R7
    end

    // all charger controls leave through flops, so the fault code and
    // every control move on the same edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_code <= `FAULT_NONE;
            charge_suspend <= 1'b0;
            charge_current_halved <= 1'b0;
            // the current output rests at the default programming
            charge_current_ma <= `ICHG_DEFAULT_MA;
            vreg_reduce <= 1'b0;
            vreg_drop_mv <= 8'h00;
            safety_timer_expired <= 1'b0;
        end else begin
            // halving has two sources; the halved flag does not say which
            fault_code <= next_fault;
            // an expired timer also stops charging
            charge_suspend <= (next_fault == `FAULT_SUSPEND) ||
                              timer_expired;                 // see R4
            charge_current_halved <= half_now;               // see R5
            charge_current_ma <= next_ma;                    // see R8
            vreg_reduce <= (next_fault == `FAULT_WARM);      // see R6
            vreg_drop_mv <= (next_fault == `FAULT_WARM) ?
                            `VREG_DROP_MV : 8'h00;           // see R6
            safety_timer_expired <= timer_expired;           // see R2
        end
    end
endmodule

// [logic/charge_timer_defines.vh]
// constants for the safety timer and thermistor control register
`ifndef CHARGE_TIMER_DEFINES_VH
`define CHARGE_TIMER_DEFINES_VH

// register offset on the register access port
`define CTRL_REG_OFFSET 8'h07

// field positions inside the control register
`define BIT_TIMER_HALFSPEED 7
`define BIT_TIMER_LIMIT_HI 6
`define BIT_TIMER_LIMIT_LO 5
`define BIT_SPARE 4
`define BIT_THERM_ENABLE 3
`define BIT_FAULT_HI 2
`define BIT_FAULT_LO 1
`define BIT_HALF_CURRENT 0

// reset values of the writable fields
`define RST_TIMER_HALFSPEED 1'b0
`define RST_TIMER_LIMIT 2'h0
// the limit field split into the two flops that hold it
`define RST_TIMER_LIMIT_HI 1'b0
`define RST_TIMER_LIMIT_LO 1'b0
`define RST_SPARE 1'b1
`define RST_THERM_ENABLE 1'b1
`define RST_HALF_CURRENT 1'b0

// timer limit encodings
`define LIMIT_27MIN 2'h0
`define LIMIT_6HOUR 2'h1
`define LIMIT_9HOUR 2'h2
`define LIMIT_OFF 2'h3

// fast-charge limits in minutes, and their length in seconds
`define TIME_27MIN_MIN 27
`define TIME_6HOUR_MIN 360
`define TIME_9HOUR_MIN 540
`define SEC_PER_MIN 60
`define SEC_27MIN 16'h0654
`define SEC_6HOUR 16'h5460
`define SEC_9HOUR 16'h7E90

// thermistor fault codes
`define FAULT_NONE 2'h0
`define FAULT_SUSPEND 2'h1
`define FAULT_COOL 2'h2
`define FAULT_WARM 2'h3

// clock rate and the second tick derived from it
`define CLK_HZ 10000000
`define TICKS_PER_SEC (`CLK_HZ)

// charge current: base plus binary weighted steps, in mA; warm-band voltage drop in mV
`define ICHG_BASE_MA 11'h226
`define ICHG_STEP_MA 11'h04B
`define ICHG_DEFAULT_MA 11'h3E8
`define VREG_DROP_MV 8'h8C

`endif

// [logic/safety_timer.v]
// fast-charge safety timer with half-rate option
`include "charge_timer_defines.vh"

module safety_timer #(
    parameter TICKS_PER_SEC = `TICKS_PER_SEC
) (
    input wire clk,
    input wire rst_n,
    input wire charge_active,   // fast charge in progress
    input wire slow_down,       // run at half rate
    input wire [1:0] limit_sel, // time limit select
    output reg expired          // limit reached, held until charge stops or the limit is set off
);
    reg [23:0] prescale;  // counts clocks within one second
    reg half_phase;       // alternates to drop every other second
    reg [15:0] seconds;   // elapsed charge seconds
    reg [15:0] limit_sec; // selected limit
    wire sec_tick;
    wire advance;
    wire run;

    // decode the limit; off leaves the timer idle
    always @* begin
        case (limit_sel)
            `LIMIT_27MIN: limit_sec = `SEC_27MIN; // see R2
            `LIMIT_6HOUR: limit_sec = `SEC_6HOUR; // see R2
            `LIMIT_9HOUR: limit_sec = `SEC_9HOUR; // see R2
            default: limit_sec = 16'hFFFF;
        endcase
    end

    assign run = charge_active && (limit_sel != `LIMIT_OFF); // see R2
    assign sec_tick = (prescale == TICKS_PER_SEC - 1);
    // skipping alternate seconds halves the rate while slowed
    assign advance = sec_tick && (!slow_down || half_phase); // see R1

    // prescaler, second counter and expiry flag
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= 24'h000000;
            half_phase <= 1'b0;
            seconds <= 16'h0000;
            expired <= 1'b0;
        end else if (!run) begin
            // a new charge cycle restarts the full limit
            prescale <= 24'h000000;
            half_phase <= 1'b0;
            seconds <= 16'h0000;
            expired <= 1'b0;
        end else begin
            if (sec_tick) begin
                prescale <= 24'h000000;
                half_phase <= ~half_phase;
            end else begin
                prescale <= prescale + 24'h000001;
            end
            if (advance && !expired) begin
                seconds <= seconds + 16'h0001;
            end
            if (seconds >= limit_sec) begin
                expired <= 1'b1;
            end
        end
    end
endmodule

// [dv/ctrl_checker_sva.sv]
// assertions on the timer and thermistor control register ports
module ctrl_checker (
    input wire clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire temp_below_cold,
    input wire temp_below_cool,
    input wire temp_above_warm,
    input wire temp_above_hot,
    input wire [3:0] charge_current_code,
    input wire charge_suspend,
    input wire charge_current_halved,
    input wire [10:0] charge_current_ma,
    input wire [7:0] vreg_drop_mv,
    input wire safety_timer_expired
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [7:0] sh; // last byte written; bits 2:1 are status and unused
    wire [5:0] kept = {sh[7:3], sh[0]};
    wire en = sh[3];
    wire [10:0] full = 11'h226 + 11'h04B * charge_current_code;
    // mirror of the writable fields
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            sh <= 8'h18;
        else if (reg_wr && reg_addr == 8'h07)
            sh <= reg_wdata;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_read_back: assert property (reg_rd && reg_addr == 8'h07
        |=> {reg_rdata[7:3], reg_rdata[0]} == $past(kept))
        else $error("read back wrong");
    a_hot_cold: assert property (
        (en && (temp_below_cold || temp_above_hot))[*4] |-> charge_suspend)
        else $error("no suspend");
    a_cool_half: assert property (
        (en && temp_below_cool && !temp_below_cold && !temp_above_hot)[*4]
        |-> charge_current_halved) else $error("no cool halving");
    a_warm_drop: assert property (
        (en && temp_above_warm && !temp_above_hot && !temp_below_cool)[*4]
        |-> vreg_drop_mv == 8'h8C) else $error("no warm drop");
    a_off_quiet: assert property ((!en)[*4] |-> vreg_drop_mv == 8'h00)
        else $error("drop while off");
    a_full_cur: assert property (
        (!sh[0] && !en && $stable(charge_current_code))[*4]
        |-> charge_current_ma == full) else $error("current wrong");
    a_half_cur: assert property (
        (sh[0] && !en && $stable(charge_current_code))[*4]
        |-> charge_current_ma == full >> 1) else $error("half wrong");
    a_limit_off: assert property ((sh[6:5] == 2'h3)[*4]
        |-> !safety_timer_expired) else $error("expiry while off");
    a_expiry_stop: assert property ($rose(safety_timer_expired)
        |-> ##[0:2] charge_suspend) else $error("expiry kept charging");
endmodule
bind charge_timer_thermistor_control ctrl_checker u_chk (.*);

// [dv/host_model.sv]
// host side: byte reads and writes on the register strobe port
module host_model (
    input wire clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h0;
    // released lines are inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {~a, ~v, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        {reg_addr, reg_rd} <= {~a, 1'b0};
        @(negedge clk);
        v = reg_rdata;
    endtask
endmodule

// [dv/charge_timer_thermistor_control_tb_top.sv]
// self-checking bench for the timer and thermistor control register
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    errors++; $display("BAD %s expected %0h seen %0h", n, e, g); end end
module charge_timer_thermistor_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int L = 6480; // 27 minutes at four clocks a second
    logic clk, rst_n = 1'b0, fast = 1'b0;
    logic [3:0] mode = 4'h0, temp = 4'h0, code = 4'h0; // cold,cool,warm,hot
    wire [7:0] a, wd, rdat, drop;
    wire wr, rd, susp, halved, expd, vred;
    wire [10:0] ma;
    int errors, checks_done, cyc;
    logic [7:0] d;
    // timer cases: control byte, regulation modes, expiry bit by case
    logic [7:0] tc[9] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'h88, 8'h08, 8'h28,
        8'h48, 8'h68};
    logic [3:0] tm[9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'hF, 4'h0, 4'h0,
        4'h0};
    logic [8:0] te = 9'h030;
    logic [3:0] tv[5] = '{4'h0, 4'hC, 4'h4, 4'h2, 4'h3};
    logic [1:0] fe[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
    charge_timer_thermistor_control #(.TICKS_PER_SEC(4)) DUT (.clk(clk),
        .rst_n(rst_n), .reg_addr(a), .reg_wr(wr), .reg_wdata(wd),
        .reg_rd(rd), .reg_rdata(rdat), .thermal_reg_active(mode[0]),
        .input_current_limit_active(mode[1]),
        .input_voltage_regulation(mode[2]),
        .dynamic_path_power_mgmt(mode[3]), .fast_charge_active(fast),
        .temp_below_cold(temp[3]), .temp_below_cool(temp[2]),
        .temp_above_warm(temp[1]), .temp_above_hot(temp[0]),
        .charge_current_code(code), .charge_suspend(susp),
        .charge_current_halved(halved), .charge_current_ma(ma),
        .vreg_reduce(vred), .vreg_drop_mv(drop), .safety_timer_expired(expd));
    host_model host (.clk(clk), .reg_addr(a), .reg_wr(wr), .reg_wdata(wd),
        .reg_rd(rd), .reg_rdata(rdat));
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        host.rd(ad, d);
        `CHK("rdata", e, d)
    endtask
    // charge on with given control and modes, look at expiry after n
    task automatic tmr(input logic [7:0] c, input logic [3:0] m,
            input int n, input logic e);
        host.wr(8'h07, c);
        mode <= m;
        fast <= 1'b1;
        repeat (n) @(posedge clk);
        @(negedge clk);
        `CHK("expired", e, expd)
        `CHK("suspend", e, susp)
        @(posedge clk);
        fast <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard, above the roughly 85k cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        `CHK("reset current", 11'h3E8, ma)
        rst_n <= 1'b1;
        rchk(8'h07, 8'h18);
        host.wr(8'h07, 8'hFF);
        rchk(8'h07, 8'hF9);
        rchk(8'h06, 8'h00);
        host.wr(8'h06, 8'h00);
        rchk(8'h07, 8'hF9);
        for (int i = 0; i < 5; i++) begin
            host.wr(8'h07, 8'h68);
            temp <= tv[i];
            repeat (4) @(posedge clk);
            rchk(8'h07, {5'h0D, fe[i], 1'b0});
            `CHK("suspend", fe[i] == 2'h1, susp)
            `CHK("halved", fe[i] == 2'h2, halved)
            `CHK("drop", fe[i] == 2'h3 ? 8'h8C : 8'h00, drop)
            `CHK("reduce", fe[i] == 2'h3, vred)
        end
        host.wr(8'h07, 8'h60);
        temp <= 4'h3;
        repeat (4) @(posedge clk);
        rchk(8'h07, 8'h60);
        `CHK("suspend off", 1'b0, susp)
        @(posedge clk);
        temp <= 4'h0;
        for (int c = 0; c < 32; c++) begin
            host.wr(8'h07, {7'h30, c[0]});
            code <= c[4:1];
            repeat (3) @(posedge clk);
            @(negedge clk);
            `CHK("current", (11'h226 + 11'h04B * c[4:1]) >> c[0], ma)
            `CHK("halved", c[0], halved)
        end
        tmr(8'h08, 4'h0, L - 10, 1'b0);
        tmr(8'h08, 4'h0, L + 20, 1'b1);
        for (int i = 0; i < 9; i++)
            tmr(tc[i], tm[i], L + 20, te[i]);
        tmr(8'h88, 4'h8, 2 * L + 30, 1'b1);
        finish_test();
    end
endmodule
